// [core/irx_pkg.sv]
// Constants shared by the infrared remote frame decoder
package irx_pkg;

  // Clock rate in MHz; all widths below are measured in this clock
  localparam int unsigned CLK_MHZ          = 25;

  // Pulse and gap figures in microseconds
  localparam int unsigned LEAD_LOW_MIN_US  = 7000;   // Leader burst lower bound
  localparam int unsigned LEAD_GAP_MIN_US  = 3500;   // Leader gap lower bound
  localparam int unsigned BIT_ONE_MIN_US   = 1120;   // Gap at or above this is a one
  localparam int unsigned TIMEOUT_US       = 20000;  // Run this long or longer aborts a frame

  // Derived cycle counts (exact products, so no rounding is needed)
  localparam int unsigned LEAD_LOW_CYC     = LEAD_LOW_MIN_US * CLK_MHZ;
  localparam int unsigned LEAD_GAP_CYC     = LEAD_GAP_MIN_US * CLK_MHZ;
  localparam int unsigned BIT_ONE_CYC      = BIT_ONE_MIN_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;

  // Run length counter width and line level when nothing is sent
  localparam int unsigned LEN_W            = 20;
  localparam logic        IDLE_LEVEL       = 1'b1;

  // Frame layout, least significant bit sent first
  localparam int unsigned FRAME_BITS       = 32;
  localparam int unsigned CNT_W            = 6;
  localparam int unsigned ID_LSB           = 0;
  localparam int unsigned ID_W             = 16;
  localparam int unsigned KEY_LSB          = 16;
  localparam int unsigned INV_LSB          = 24;
  localparam int unsigned BYTE_W           = 8;
  localparam int unsigned DIG_W            = 4;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    LEADER_SEEN_STATE,
    PAYLOAD_CAPTURE_STATE
  } irx_seq_t;

  // True when a measured run reaches a threshold
  function automatic logic irx_at_least(input logic [LEN_W-1:0] len,
                                        input logic [LEN_W-1:0] thr);
    irx_at_least = (len >= thr);
  endfunction : irx_at_least

endpackage : irx_pkg

// [core/irx_width_meter.sv]
// Run length meter for the demodulated infrared line
`timescale 1ns/1ns
module irx_width_meter
  import irx_pkg::*;
(
  input  wire logic             mclk,       // System clock
  input  wire logic             reset,      // Asynchronous reset, active high
  input  wire logic             level_in,   // Demodulated line level
  output logic                  run_done,   // One-cycle pulse when a run ends
  output logic                  run_level,  // Level of the run that just ended
  output logic [LEN_W-1:0]      run_len,    // Cycles of the run that just ended
  output logic [LEN_W-1:0]      cur_len     // Cycles of the run in progress
);

  logic             prev_q, prev_d;
  logic [LEN_W-1:0] cnt_q, cnt_d;
  logic             done_q, done_d;
  logic             lvl_q, lvl_d;
  logic [LEN_W-1:0] len_q, len_d;

  // Count the current level; saturate so an idle line never wraps into a short run
  always_comb
  begin
    prev_d = level_in;
    done_d = 1'b0;
    lvl_d  = lvl_q;
    len_d  = len_q;
    if (level_in != prev_q)
    begin
      done_d = 1'b1;
      lvl_d  = prev_q;
      len_d  = cnt_q;
      cnt_d  = LEN_W'(1);
    end
    else if (cnt_q == {LEN_W{1'b1}})
      cnt_d = cnt_q;
    else
      cnt_d = cnt_q + 1'b1;
  end

  // Register stage
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prev_q <= IDLE_LEVEL;
      cnt_q  <= '0;
      done_q <= 1'b0;
      lvl_q  <= IDLE_LEVEL;
      len_q  <= '0;
    end
    else
    begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      lvl_q  <= lvl_d;
      len_q  <= len_d;
    end
  end

  assign run_done  = done_q;
  assign run_level = lvl_q;
  assign run_len   = len_q;
  assign cur_len   = cnt_q;

endmodule : irx_width_meter

// [core/irx_decoder.sv]
// Infrared remote frame decoder: symbol detector, sequencer and display register
// Notes on behaviour
// R1: A frame is a leader, then the key fields, then one end bit that closes it.
// R2: After the leader the decoder gathers a 16-bit remote identifier and an 8-bit key field.
// R3: The symbol detector checks the line for the leader and reports it to the sequencer.
// R4: The sequencer goes from idle to the leader-seen state as soon as a leader is reported.
// R5: From the leader-seen state it enters payload capture once the identifier field begins.
// R6: In payload capture identifier, key and inverted key are kept and passed to the display.
// R7: All logic runs from one clock and every time measurement counts that clock.
// R8: The identifier tells remotes apart and the key code tells which key was pressed.
// R9: Digits zero and one show the inverted key nibbles, digits two and three the key nibbles.
// R10: Digits four to seven show the four identifier nibbles, lowest nibble on digit four.
// R11: Symbols are told apart by counted widths, and the decoder idles after end bit or timeout.
// R12: The display updates only on a full frame whose inverted key complements the key.
`timescale 1ns/1ns
module irx_decoder
  import irx_pkg::*;
#(
  parameter int unsigned LEAD_LOW  = LEAD_LOW_CYC,  // Leader burst cycles
  parameter int unsigned LEAD_GAP  = LEAD_GAP_CYC,  // Leader gap cycles
  parameter int unsigned BIT_ONE   = BIT_ONE_CYC,   // Gap cycles that mark a one
  parameter int unsigned TIMEOUT   = TIMEOUT_CYC    // Abort after a run this long
)
(
  input  wire logic             mclk,                // System clock
  input  wire logic             reset,               // Asynchronous reset, active high
  input  wire logic             ir_line,             // Demodulated receiver output, idle high
  output logic [DIG_W-1:0]      display_digit_zero,  // Inverted key, low nibble
  output logic [DIG_W-1:0]      display_digit_one,   // Inverted key, high nibble
  output logic [DIG_W-1:0]      display_digit_two,   // Key, low nibble
  output logic [DIG_W-1:0]      display_digit_three, // Key, high nibble
  output logic [DIG_W-1:0]      display_digit_four,  // Identifier nibble 0
  output logic [DIG_W-1:0]      display_digit_five,  // Identifier nibble 1
  output logic [DIG_W-1:0]      display_digit_six,   // Identifier nibble 2
  output logic [DIG_W-1:0]      display_digit_seven, // Identifier nibble 3
  output logic                  frame_done           // One-cycle pulse on accepted frame
);

  localparam logic [LEN_W-1:0] LEAD_LOW_T = LEN_W'(LEAD_LOW);
  localparam logic [LEN_W-1:0] LEAD_GAP_T = LEN_W'(LEAD_GAP);
  localparam logic [LEN_W-1:0] BIT_ONE_T  = LEN_W'(BIT_ONE);
  localparam logic [LEN_W-1:0] TIMEOUT_T  = LEN_W'(TIMEOUT);

  logic                  run_done;
  logic                  run_level;
  logic [LEN_W-1:0]      run_len;
  logic [LEN_W-1:0]      cur_len;

  irx_seq_t              state_q, state_d;
  logic [FRAME_BITS-1:0] data_q, data_d;
  logic [CNT_W-1:0]      bit_cnt_q, bit_cnt_d;
  logic [FRAME_BITS-1:0] display_q, display_d;
  logic                  done_q, done_d;
  logic                  lead_ok, gap_ok, frame_ok, timed_out, check_ok;

  // Width measurement of every low burst and high gap, in mclk cycles
  irx_width_meter u_meter (
    .mclk      (mclk),
    .reset     (reset),
    .level_in  (ir_line),
    .run_done  (run_done),
    .run_level (run_level),
    .run_len   (run_len),
    .cur_len   (cur_len)
  );

  // Symbol detector verdicts
  assign lead_ok   = run_done && !run_level && irx_at_least(run_len, LEAD_LOW_T);   // R3 R11
  assign gap_ok    = run_done && run_level && irx_at_least(run_len, LEAD_GAP_T);    // R5 R11
  assign timed_out = irx_at_least(cur_len, TIMEOUT_T);                              // R11
  assign check_ok  = (data_q[INV_LSB +: BYTE_W] == ~data_q[KEY_LSB +: BYTE_W]);     // R12
  assign frame_ok  = (state_q == PAYLOAD_CAPTURE_STATE) && (bit_cnt_q == CNT_W'(FRAME_BITS))
                     && run_done && !run_level && check_ok;                         // R1 R12

  // Sequencer and payload shifter; repeat codes have a short gap and drop back to idle
  always_comb
  begin
    state_d   = state_q;
    data_d    = data_q;
    bit_cnt_d = bit_cnt_q;
    display_d = display_q;
    done_d    = 1'b0;
    case (state_q)
      SEQ_IDLE:
      begin
        if (lead_ok)
          state_d = LEADER_SEEN_STATE;                                   // R4
      end
      LEADER_SEEN_STATE:
      begin
        bit_cnt_d = '0;
        if (timed_out)
          state_d = SEQ_IDLE;                                            // R11
        else if (run_done && run_level)
          state_d = gap_ok ? PAYLOAD_CAPTURE_STATE : SEQ_IDLE;           // R5
      end
      PAYLOAD_CAPTURE_STATE:
      begin
        if (timed_out)
          state_d = SEQ_IDLE;                                            // R11
        else if (run_done && run_level && bit_cnt_q < CNT_W'(FRAME_BITS))
        begin
          // First bit lands lowest after all shifts: identifier, key, inverted key
          data_d    = {irx_at_least(run_len, BIT_ONE_T), data_q[FRAME_BITS-1:1]}; // R2 R6 R11
          bit_cnt_d = bit_cnt_q + 1'b1;                                  // R2
        end
        else if (run_done && !run_level && bit_cnt_q == CNT_W'(FRAME_BITS))
        begin
          // End bit closes the frame; a failed check is dropped silently
          state_d = SEQ_IDLE;                                            // R1 R11
          if (check_ok)
          begin
            display_d = {data_q[ID_LSB +: ID_W], data_q[KEY_LSB +: BYTE_W],
                         data_q[INV_LSB +: BYTE_W]};                     // R6 R8 R9 R10 R12
            done_d    = 1'b1;
          end
        end
      end
      default:
        state_d = SEQ_IDLE;
    endcase
  end

  // Register stage, one clock for everything
  always_ff @(posedge mclk or posedge reset)                             // R7
  begin
    if (reset)
    begin
      state_q   <= SEQ_IDLE;
      data_q    <= '0;
      bit_cnt_q <= '0;
      display_q <= '0;
      done_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      data_q    <= data_d;
      bit_cnt_q <= bit_cnt_d;
      display_q <= display_d;
      done_q    <= done_d;
    end
  end

  // Digit fan-out straight from the display register
  assign display_digit_zero  = display_q[0*DIG_W +: DIG_W];              // R9
  assign display_digit_one   = display_q[1*DIG_W +: DIG_W];              // R9
  assign display_digit_two   = display_q[2*DIG_W +: DIG_W];              // R9
  assign display_digit_three = display_q[3*DIG_W +: DIG_W];              // R9
  assign display_digit_four  = display_q[4*DIG_W +: DIG_W];              // R10
  assign display_digit_five  = display_q[5*DIG_W +: DIG_W];              // R10
  assign display_digit_six   = display_q[6*DIG_W +: DIG_W];              // R10
  assign display_digit_seven = display_q[7*DIG_W +: DIG_W];              // R10
  assign frame_done          = done_q;

  // Checks on sequencer and display; all quiet while reset is high
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_leader_burst;
    state_q == SEQ_IDLE && lead_ok && !timed_out;
  endsequence

  sequence s_leader_gap;
    state_q == LEADER_SEEN_STATE && gap_ok && !timed_out;
  endsequence

  // A data gap that shifts one more bit in
  sequence s_data_gap;
    state_q == PAYLOAD_CAPTURE_STATE && run_done && run_level && !timed_out
      && bit_cnt_q < CNT_W'(FRAME_BITS);
  endsequence

  // End burst of a full frame whose check bytes disagree
  sequence s_bad_end;
    state_q == PAYLOAD_CAPTURE_STATE && bit_cnt_q == CNT_W'(FRAME_BITS) && run_done
      && !run_level && !check_ok;
  endsequence

  a_leader_enter: assert property (s_leader_burst |=> state_q == LEADER_SEEN_STATE) // R3 R4
    else $error("leader not taken");
  a_gap_capture: assert property (s_leader_burst ##[1:1000] s_leader_gap
                                  |=> state_q == PAYLOAD_CAPTURE_STATE && bit_cnt_q == 0) // R5
    else $error("capture not entered after gap");
  a_short_burst: assert property (state_q == SEQ_IDLE && run_done && !run_level
                                  && run_len < LEAD_LOW_T |=> state_q == SEQ_IDLE) // R11
    else $error("short burst taken as leader");
  // A leader gap too short for a frame is a repeat code and falls back to idle
  a_repeat_drop: assert property (state_q == LEADER_SEEN_STATE && run_done && run_level // R5 R11
                                  && !gap_ok |=> state_q == SEQ_IDLE)
    else $error("short leader gap not dropped");
  a_timeout_idle: assert property (state_q != SEQ_IDLE && timed_out |=> state_q == SEQ_IDLE) // R11
    else $error("timeout ignored");
  a_bit_limit: assert property (bit_cnt_q <= CNT_W'(FRAME_BITS)) // R2
    else $error("bit count overrun");
  // Each data gap adds exactly one bit at the top of the shifter
  a_bit_shift: assert property (s_data_gap |=> bit_cnt_q == $past(bit_cnt_q) + 1'b1 // R2 R11
                              && data_q[FRAME_BITS-1] == $past(irx_at_least(run_len, BIT_ONE_T)))
    else $error("data bit not shifted");
  a_display_cause: assert property (!$stable(display_q) |-> $past(frame_ok)) // R12
    else $error("display changed without good frame");
  // A failed check leaves display and pulse untouched
  a_bad_drop: assert property (s_bad_end |=> $stable(display_q) && !frame_done // R12
                               && state_q == SEQ_IDLE)
    else $error("failed frame reached display");
  a_key_digits: assert property (frame_ok |=> // R9
                                 display_digit_zero == $past(data_q[INV_LSB +: DIG_W])
                                 && display_digit_one == $past(data_q[INV_LSB+DIG_W +: DIG_W])
                                 && display_digit_two == $past(data_q[KEY_LSB +: DIG_W])
                                 && display_digit_three == $past(data_q[KEY_LSB+DIG_W +: DIG_W]))
    else $error("key digits misplaced");
  a_id_digits: assert property (frame_ok |=> // R10
                                display_digit_four == $past(data_q[ID_LSB +: DIG_W])
                                && display_digit_five == $past(data_q[ID_LSB+DIG_W +: DIG_W])
                                && display_digit_six == $past(data_q[ID_LSB+2*DIG_W +: DIG_W])
                                && display_digit_seven == $past(data_q[ID_LSB+3*DIG_W +: DIG_W]))
    else $error("identifier digits misplaced");
  a_done_pulse: assert property (frame_ok |=> frame_done // R1
                                 ##1 !frame_done && state_q == SEQ_IDLE)
    else $error("frame done pulse wrong");
  // The pulse only ever follows an accepted end burst
  a_done_cause: assert property (frame_done |-> $past(frame_ok)) // R6 R12
    else $error("done pulse without frame");

endmodule : irx_decoder

// [verification/irx_remote_model.sv]
// Behavioural infrared remote: leader, 32 data bits and end burst on an idle-high line
`timescale 1ns/1ns
module irx_remote_model
  import irx_pkg::*;
(
  input  wire logic        mclk,       // System clock
  input  wire logic        go,         // Start one frame
  input  wire logic [31:0] word,       // Frame bits, least significant sent first
  input  wire logic        short_gap,  // Repeat-style leader with a short gap
  input  wire logic        slow,       // Stretch every data burst and gap
  input  wire logic        cut,        // Stop sending after ten bits
  output logic             ir_line,    // Demodulated line, idle high
  output logic             busy        // High while a frame is on the line
);
  int unsigned b;
  int unsigned i;

  // Hold a level for n falling edges
  task automatic hold(input logic lvl, input int unsigned n);
    ir_line = lvl;
    repeat (n) @(negedge mclk);
  endtask : hold

  // Frame generator, one process so the line has a single driver; it rests idle until go.
  // Slow mode widens runs so threshold margins get exercised.
  // Busy drops by non-blocking assignment, so the bench sees it one falling edge late, always.
  initial
  begin
    ir_line = IDLE_LEVEL;
    busy    = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (go)
      begin
        busy <= 1'b1;
        b    = slow ? 6 : 4;
        @(negedge mclk);
        hold(1'b0, 48);
        hold(1'b1, short_gap ? 12 : 24);
        if (short_gap)
          hold(1'b0, b);
        else
        begin
          for (i = 0; i < 32 && !(cut && i == 10); i++)
          begin
            hold(1'b0, b);
            hold(1'b1, word[i] ? b + 8 : b);
          end
          if (!cut)
            hold(1'b0, b);
        end
        ir_line = IDLE_LEVEL;
        busy    <= 1'b0;
      end
    end
  end
endmodule : irx_remote_model

// [verification/irx_decoder_bench.sv]
// Self-checking bench for the infrared remote frame decoder
`timescale 1ns/1ns
module irx_decoder_bench;
  import irx_pkg::*;
  logic             mclk;
  logic             reset;
  logic             go;
  logic             short_gap;
  logic             slow;
  logic             cut;
  logic [31:0]      word;
  logic             ir_line;
  logic             busy;
  logic [DIG_W-1:0] dig [8];
  logic             frame_done;
  logic [31:0]      shown;
  int               bad_count;
  int               check_count;
  int               cyc;
  logic [31:0]      digits_seen;
  localparam int    DONE_EDGES = 2;  // Meter register, then decoder register

  irx_decoder #(.LEAD_LOW(40), .LEAD_GAP(20), .BIT_ONE(8), .TIMEOUT(200)) dut (
    .mclk(mclk), .reset(reset), .ir_line(ir_line),
    .display_digit_zero(dig[0]), .display_digit_one(dig[1]), .display_digit_two(dig[2]),
    .display_digit_three(dig[3]), .display_digit_four(dig[4]), .display_digit_five(dig[5]),
    .display_digit_six(dig[6]), .display_digit_seven(dig[7]), .frame_done(frame_done));

  irx_remote_model remote (.mclk(mclk), .go(go), .word(word), .short_gap(short_gap),
    .slow(slow), .cut(cut), .ir_line(ir_line), .busy(busy));

  // All eight digits as one word, digit seven on top
  assign digits_seen = {dig[7], dig[6], dig[5], dig[4], dig[3], dig[2], dig[1], dig[0]};

  // Clock, 40 ns period
  always #20 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One frame from the remote, then judge pulse count, latency and digits
  task automatic send(input logic [15:0] id, input logic [7:0] key, input logic [7:0] inv,
                      input logic sg, input logic sl, input logic ct);
    int unsigned n;
    int unsigned at;
    int unsigned k;
    logic        ok;
    @(negedge mclk);
    word      = {inv, key, id};
    short_gap = sg;
    slow      = sl;
    cut       = ct;
    go        = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    ok = (inv === ~key) && !sg && !ct;
    n  = 0;
    at = 0;
    while (busy === 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    // Long enough for the timeout run to expire after an aborted frame
    for (k = 1; k <= 260; k++)
    begin
      @(negedge mclk);
      if (frame_done === 1'b1)
      begin
        n++;
        at = k;
      end
    end
    check("done pulses", 32'(ok), n);
    if (ok)
    begin
      // The wait loop ends one falling edge after the line rises, so one edge is already spent
      check("done delay", DONE_EDGES - 1, at);
      shown = {id, key, inv};
    end
    check("display word", shown, digits_seen);
  endtask : send

  // Several key codes with distinct identifiers
  task automatic t_keys;
    logic [7:0] keys [4];
    keys = '{8'h0F, 8'h13, 8'h10, 8'h00};
    for (int i = 0; i < 4; i++)
      send(16'hC3A5 + 16'(i * 16'h1111), keys[i], ~keys[i], 1'b0, 1'b0, 1'b0);
  endtask : t_keys

  task automatic t_bad_inverse;
    send(16'hBEEF, 8'h12, 8'h12, 1'b0, 1'b0, 1'b0);
  endtask : t_bad_inverse

  task automatic t_repeat_code;
    send(16'h0F0F, 8'h1A, 8'hE5, 1'b1, 1'b0, 1'b0);
    send(16'h7E81, 8'h1B, 8'hE4, 1'b0, 1'b0, 1'b0);
  endtask : t_repeat_code

  task automatic t_abort;
    send(16'h5A5A, 8'h1E, 8'hE1, 1'b0, 1'b0, 1'b1);
    send(16'h2468, 8'h0C, 8'hF3, 1'b0, 1'b0, 1'b0);
  endtask : t_abort

  // Boundary words with stretched runs
  task automatic t_slow_edges;
    send(16'hFFFF, 8'hFF, 8'h00, 1'b0, 1'b1, 1'b0);
    send(16'h0000, 8'h00, 8'hFF, 1'b0, 1'b1, 1'b0);
  endtask : t_slow_edges

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Watchdog against a hung frame
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  end

  // Main sequence
  initial
  begin
    mclk        = 1'b0;
    reset       = 1'b1;
    go          = 1'b0;
    short_gap   = 1'b0;
    slow        = 1'b0;
    cut         = 1'b0;
    word        = 32'h0;
    shown       = 32'h0;
    bad_count   = 0;
    check_count = 0;
    cyc         = 0;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    check("reset digits", 32'h0, digits_seen);
    t_keys();
    t_bad_inverse();
    t_repeat_code();
    t_abort();
    t_slow_edges();
    test_done();
  end
endmodule : irx_decoder_bench
